//--- design/dsa_dev.sv
// device end: serial command execution for register and memory access
// Behaviour
// - register read returns upper half, then lower
// - register write replaces all 32 bits
// - register write while running gives bus error
// - host sends write operand upper half first
// - finished register write returns 0FFFF
// - memory attributes from low 5 attribute bits
// - word/long addresses forced to natural alignment
// - host follows memory read with long address
// - byte read low 16 bits; word 16, long 32
// - good read bit16 clear; error gives 10001
// - host sends write address then sized data
// - write returns 0FFFF, or 10001 on error
// - memory read sets block start for dumps
// - pointer advances by size, kept in register
// - dump legal only after dump, null, read
// - null command keeps the dump pointer
// - dump size decoded afresh each command
// - size 00 byte, 01 word, 10 long
// - host gives every address as two words
// - transfers during memory access get not-ready
// - valid results top bit 0, others 1
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dsa_dev (
    input wire logic sys_clk,
    input wire logic rst,
    dsa_link_if.dev link,
    input wire logic core_halted,
    input wire logic [4:0] attr_bits,
    output logic [3:0] reg_sel,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    output logic mem_req,
    output logic mem_wr,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [1:0] mem_tt,
    output logic [2:0] mem_tm,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    output logic [31:0] bp_high_addr
);
    import dsa_pkg::*;

    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic di_s1;
        logic di_s2;
        logic [4:0] bitcnt;
        logic [15:0] rx;
        logic [16:0] sh;
        dsa_dev_st_t st;
        logic [15:0] cmd;
        logic [31:0] addr;
        logic [31:0] data;
        logic err;
        logic dump_ok;
        logic [31:0] bhar;
        logic [16:0] res_hi;
        logic [15:0] res_lo;
        logic long_res;
        logic mreq;
        logic mwr;
        logic [1:0] msz;
        logic [31:0] maddr;
        logic [31:0] mwdata;
        logic [4:0] mattr;
        logic rwr;
        logic [3:0] rsel;
        logic [31:0] rwdata;
    } dsa_dev_t;

    dsa_dev_t q;
    dsa_dev_t n;

    function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
        if (sz == SZ_WORD)
            align = {a[31:1], 1'b0};
        else if (sz == SZ_LONG)
            align = {a[31:2], 2'b00};
        else
            align = a;
    endfunction : align

    function automatic logic [31:0] step(input logic [1:0] sz);
        if (sz == SZ_WORD)
            step = 32'h00000002;
        else if (sz == SZ_LONG)
            step = 32'h00000004;
        else
            step = 32'h00000001;
    endfunction : step

    logic fend;
    logic go;
    logic [31:0] go_addr;
    logic [15:0] w;
    logic [1:0] wsz;
    logic wlow_ok;

    always_comb
    begin
        n = q;
        fend = 1'b0;
        go = 1'b0;
        go_addr = q.addr;
        n.clk_s1 = link.dsclk;
        n.clk_s2 = q.clk_s1;
        n.clk_s3 = q.clk_s2;
        n.di_s1 = link.dsi;
        n.di_s2 = q.di_s1;
        n.rwr = 1'b0;
        if (q.clk_s2 && !q.clk_s3)
        begin
            n.sh = {q.sh[15:0], 1'b0};
            n.rx = {q.rx[14:0], q.di_s2};
            if (q.bitcnt == LAST_BIT)
            begin
                n.bitcnt = 5'h00;
                fend = 1'b1;
            end
            else
                n.bitcnt = q.bitcnt + 5'h01;
        end
        w = n.rx;
        wsz = w[SZ_LSB+1:SZ_LSB];
        wlow_ok = (w[5:0] == 6'h00) && (wsz != SZ_RSVD);
        if (q.st == S_RREG)
        begin
            n.res_hi = {1'b0, reg_rdata[31:16]};
            n.res_lo = reg_rdata[15:0];
            n.long_res = 1'b1;
            n.st = S_RES;
        end
        if (q.mreq && mem_ack)
        begin
            n.mreq = 1'b0;
            n.st = S_RES;
            n.long_res = !q.mwr && !mem_err && (q.msz == SZ_LONG);
            n.res_lo = mem_rdata[15:0];
            if (mem_err)
                n.res_hi = RSP_BERR;
            else if (q.mwr)
                n.res_hi = RSP_DONE;
            else if (q.msz == SZ_LONG)
                n.res_hi = {1'b0, mem_rdata[31:16]};
            else
                n.res_hi = {1'b0, mem_rdata[15:0]};
            if (!q.mwr)
                n.bhar = q.maddr + step(q.msz);
        end
        if (fend)
        begin
            n.sh = RSP_NOTRDY;
            case (q.st)
                S_CMD:
                begin
                    n.sh = RSP_ILL;
                    n.dump_ok = 1'b0;
                    n.cmd = w;
                    if (w == OP_NULL)
                    begin
                        n.sh = RSP_DONE;
                        n.dump_ok = q.dump_ok;
                    end
                    else if (w[15:8] == OP_READ_DATA_REG_CMD && w[7:4] == OP_REGGRP)
                    begin
                        if (core_halted)
                        begin
                            n.rsel = w[3:0];
                            n.st = S_RREG;
                            n.sh = RSP_NOTRDY;
                        end
                        else
                            n.sh = RSP_BERR;
                    end
                    else if (w[15:8] == OP_WRREG && w[7:4] == OP_REGGRP)
                    begin
                        n.err = !core_halted;
                        n.st = S_DHI;
                        n.sh = RSP_NOTRDY;
                    end
                    else if ((w[15:8] == OP_READ || w[15:8] == OP_WRITE) && wlow_ok)
                    begin
                        n.dump_ok = (w[15:8] == OP_READ);
                        n.st = S_AHI;
                        n.sh = RSP_NOTRDY;
                    end
                    else if (w[15:8] == OP_DUMP && wlow_ok && q.dump_ok)
                    begin
                        n.dump_ok = 1'b1;
                        go = 1'b1;
                        go_addr = q.bhar;
                    end
                end
                S_AHI:
                begin
                    n.addr[31:16] = w;
                    n.st = S_ALO;
                end
                S_ALO:
                begin
                    n.addr[15:0] = w;
                    go_addr = {q.addr[31:16], w};
                    n.data = 32'h00000000;
                    if (q.cmd[15:8] == OP_WRITE)
                        n.st = (q.cmd[SZ_LSB+1:SZ_LSB] == SZ_LONG) ? S_DHI : S_DLO;
                    else
                        go = 1'b1;
                end
                S_DHI:
                begin
                    n.data[31:16] = w;
                    n.st = S_DLO;
                end
                S_DLO:
                begin
                    n.data[15:0] = w;
                    if (q.cmd[15:8] == OP_WRREG)
                    begin
                        n.st = S_CMD;
                        if (q.err)
                            n.sh = RSP_BERR;
                        else
                        begin
                            n.rwr = 1'b1;
                            n.rsel = q.cmd[3:0];
                            n.rwdata = {q.data[31:16], w};
                            n.sh = RSP_DONE;
                        end
                    end
                    else
                        go = 1'b1;
                end
                S_RES:
                begin
                    n.sh = q.res_hi;
                    n.st = q.long_res ? S_RLO : S_CMD;
                end
                S_RLO:
                begin
                    n.sh = {1'b0, q.res_lo};
                    n.st = S_CMD;
                end
                default:
                    n.sh = RSP_NOTRDY;
            endcase
        end
        if (go)
        begin
            n.mreq = 1'b1;
            n.mwr = (q.cmd[15:8] == OP_WRITE) && (q.st != S_CMD);
            n.msz = (q.st == S_CMD) ? wsz : q.cmd[SZ_LSB+1:SZ_LSB];
            n.maddr = align(go_addr, n.msz);
            n.mwdata = n.data;
            n.mattr = attr_bits;
            n.st = S_MEM;
            n.sh = RSP_NOTRDY;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= n;
    end

    assign link.dso = q.sh[16];
    assign reg_sel = q.rsel;
    assign reg_wr = q.rwr;
    assign reg_wdata = q.rwdata;
    assign mem_req = q.mreq;
    assign mem_wr = q.mwr;
    assign mem_size = q.msz;
    assign mem_addr = q.maddr;
    assign mem_wdata = q.mwdata;
    assign mem_tt = q.mattr[4:ATTR_TT_LSB];
    assign mem_tm = q.mattr[ATTR_TT_LSB-1:0];
    assign bp_high_addr = q.bhar;
endmodule : dsa_dev
`default_nettype wire

//--- design/dsa_host.sv
// host end: shifts one 17-bit frame per software command over the serial link
`timescale 1ns/1ps
`default_nettype none
module dsa_host (
    input wire logic sys_clk,
    input wire logic rst,
    dsa_link_if.host link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import dsa_pkg::*;

    typedef struct packed {
        logic do_s1;
        logic do_s2;
        dsa_host_st_t st;
        logic [3:0] cnt;
        logic [4:0] bits;
        logic [16:0] tx;
        logic [16:0] rx;
        logic [16:0] resp;
        logic clk;
        logic rd_ack;
        logic [31:0] rdata;
    } dsa_host_t;

    dsa_host_t q;
    dsa_host_t n;
    logic busy;
    logic cmd_wr;

    // a command write stalls while a frame or its gap is running
    assign busy = (q.st != H_IDLE);
    assign cmd_wr = avs_write && (avs_address == HR_CMD);
    assign avs_waitrequest = (avs_read && !q.rd_ack) || (cmd_wr && busy);

    always_comb
    begin
        n = q;
        n.do_s1 = link.dso;
        n.do_s2 = q.do_s1;
        n.rd_ack = 1'b0;
        if (avs_read && !q.rd_ack)
        begin
            n.rd_ack = 1'b1;
            if (avs_address == HR_STAT)
                n.rdata = {31'h00000000, busy};
            else if (avs_address == HR_RESP)
                n.rdata = {15'h0000, q.resp};
            else
                n.rdata = 32'h00000000;
        end
        case (q.st)
            H_IDLE:
            begin
                if (cmd_wr)
                begin
                    // leading bit is the host status bit, always zero
                    n.tx = {1'b0, avs_writedata[15:0]};
                    n.cnt = 4'h0;
                    n.bits = 5'h00;
                    n.st = H_LOW;
                end
            end
            H_LOW:
            begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == HALF_M1)
                begin
                    n.cnt = 4'h0;
                    n.clk = 1'b1;
                    n.rx = {q.rx[15:0], q.do_s2};
                    n.st = H_HIGH;
                end
            end
            H_HIGH:
            begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == HALF_M1)
                begin
                    n.cnt = 4'h0;
                    n.clk = 1'b0;
                    n.tx = {q.tx[15:0], 1'b0};
                    if (q.bits == LAST_BIT)
                    begin
                        n.resp = q.rx;
                        n.st = H_GAP;
                    end
                    else
                    begin
                        n.bits = q.bits + 5'h01;
                        n.st = H_LOW;
                    end
                end
            end
            default:
            begin
                // idle time lets the device settle its next response
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == GAP_M1)
                    n.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= n;
    end

    assign link.dsclk = q.clk;
    assign link.dsi = q.tx[16];
    assign avs_readdata = q.rdata;
endmodule : dsa_host
`default_nettype wire

//--- design/dsa_link_if.sv
// serial link between the debug host and the debug access device
`timescale 1ns/1ps
`default_nettype none
interface dsa_link_if;
    logic dsclk;
    logic dsi;
    logic dso;
    modport host (output dsclk, output dsi, input dso);
    modport dev (input dsclk, input dsi, output dso);
endinterface : dsa_link_if
`default_nettype wire

//--- design/dsa_pkg.sv
// constants and types shared by both ends of the debug serial access link
package dsa_pkg;
    localparam int SYS_NS = 25;
    localparam int LINK_NS = 200;
    localparam int GAP_NS = 200;
    localparam logic [3:0] HALF_M1 = 4'(LINK_NS / SYS_NS / 2 - 1);
    localparam logic [3:0] GAP_M1 = 4'(GAP_NS / SYS_NS - 1);
    localparam int FRAME_BITS = 17;
    localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);
    localparam logic [16:0] RSP_DONE = 17'h0FFFF;
    localparam logic [16:0] RSP_NOTRDY = 17'h10000;
    localparam logic [16:0] RSP_BERR = 17'h10001;
    localparam logic [16:0] RSP_ILL = 17'h1FFFF;
    localparam logic [15:0] OP_NULL = 16'h0000;
    localparam logic [7:0] OP_READ_DATA_REG_CMD = 8'h21;
    localparam logic [7:0] OP_WRREG = 8'h20;
    localparam logic [3:0] OP_REGGRP = 4'h8;
    localparam logic [7:0] OP_READ = 8'h19;
    localparam logic [7:0] OP_WRITE = 8'h18;
    localparam logic [7:0] OP_DUMP = 8'h1D;
    localparam int SZ_LSB = 6;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_RSVD = 2'h3;
    localparam int ATTR_TT_LSB = 3;
    localparam logic [3:0] HR_CMD = 4'h0;
    localparam logic [3:0] HR_STAT = 4'h4;
    localparam logic [3:0] HR_RESP = 4'h8;
    typedef enum logic [3:0] {
        S_CMD, S_AHI, S_ALO, S_DHI, S_DLO, S_RREG, S_MEM, S_RES, S_RLO
    } dsa_dev_st_t;
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} dsa_host_st_t;
endpackage : dsa_pkg

//--- verification/debug_serial_reg_mem_access_tb.sv
// bench: host and device ends joined over the link, with core and memory models
`timescale 1ns/1ps
`default_nettype none
module debug_serial_reg_mem_access_tb;
    import dsa_pkg::*;
    logic sys_clk, rst, core_halted, mem_ack, mem_err, avs_read, avs_write, err_en, clk_p;
    logic avs_waitrequest, reg_wr, mem_req, mem_wr, acc_wr;
    logic [3:0] avs_address, reg_sel;
    logic [4:0] attr_bits, acc_at;
    logic [1:0] mem_tt, mem_size, acc_sz;
    logic [2:0] mem_tm;
    logic [7:0] dly;
    logic [16:0] cap;
    logic [31:0] avs_writedata, avs_readdata, reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, bp_high_addr;
    logic [31:0] acc_addr, acc_wd;
    logic [31:0] regs [16];
    int seed, fail_count, n_checks, cyc, s;
    dsa_link_if link();
    dsa_host i_dsa_host (.sys_clk(sys_clk), .rst(rst), .link(link), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dsa_dev i_dsa_dev (.sys_clk(sys_clk), .rst(rst), .link(link), .core_halted(core_halted),
        .attr_bits(attr_bits), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_wr(mem_wr), .mem_size(mem_size), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_tt(mem_tt), .mem_tm(mem_tm), .mem_ack(mem_ack), .mem_err(mem_err),
        .mem_rdata(mem_rdata), .bp_high_addr(bp_high_addr));
    dsa_link_asserts i_dsa_link_asserts (.sys_clk(sys_clk), .rst(rst), .dsclk(link.dsclk),
        .dsi(link.dsi), .dso(link.dso));
    assign reg_rdata = regs[reg_sel];
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0] ^ 16'hA55A, ~a[31:16]};
    endfunction : pat
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    // core registers, memory with random latency, and a tap on the host data line
    always @(posedge sys_clk)
    begin
        mem_ack <= 1'b0;
        clk_p <= link.dsclk;
        if (link.dsclk && !clk_p)
            cap <= {cap[15:0], link.dsi};
        if (reg_wr)
            regs[reg_sel] <= reg_wdata;
        if (mem_req && !mem_ack && dly != 8'h00)
            dly <= dly - 8'h01;
        else if (mem_req && !mem_ack)
        begin
            mem_ack <= 1'b1;
            mem_err <= err_en;
            mem_rdata <= pat(mem_addr);
            {acc_wr, acc_sz, acc_at, acc_addr, acc_wd} <= {mem_wr, mem_size, mem_tt, mem_tm, mem_addr, mem_wdata};
            dly <= 8'($random(seed));
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : av
    task automatic xfer(input logic [15:0] w, output logic [31:0] r);
        logic [31:0] st;
        av(HR_CMD, 1'b1, {16'h0, w}, st);
        st = 32'h1;
        while (st[0] !== 1'b0)
            av(HR_STAT, 1'b0, 32'h0, st);
        check("frame bits", {15'h0, cap}, {16'h0, w});
        av(HR_RESP, 1'b0, 32'h0, r);
    endtask : xfer
    // words sent while the device is not ready are dropped, so repeating them is safe
    task automatic poll(input logic [15:0] w, output logic [31:0] r);
        r = 32'(RSP_NOTRDY);
        for (int n = 0; n < 8 && r == 32'(RSP_NOTRDY); n++)
            xfer(w, r);
    endtask : poll
    task automatic fetch(input logic [1:0] sz, input logic [31:0] a);
        logic [31:0] r, al, e;
        al = a & ~((32'h1 << sz) - 32'h1);
        e = pat(al);
        poll(16'h0, r);
        check("address", acc_addr, al);
        check("read size", {30'h0, acc_sz}, {30'h0, sz});
        check("attributes", {26'h0, acc_wr, acc_at}, {27'h0, attr_bits});
        if (err_en)
            check("read error", r, 32'(RSP_BERR));
        else if (sz == SZ_BYTE)
            check("byte", r & 32'h100FF, {24'h0, e[7:0]});
        else
            check("first half", r, {16'h0, sz == SZ_LONG ? e[31:16] : e[15:0]});
        if (sz == SZ_LONG && !err_en)
        begin
            xfer(16'h0, r);
            check("second half", r, {16'h0, e[15:0]});
        end
        if (a == al && !err_en)
            check("pointer", bp_high_addr, al + (32'h1 << sz));
    endtask : fetch
    task automatic mem_rd(input logic [1:0] sz, input logic [31:0] a);
        logic [31:0] r;
        attr_bits <= 5'($random(seed));
        xfer({OP_READ, sz, 6'h00}, r);
        xfer(a[31:16], r);
        check("not ready", r, 32'(RSP_NOTRDY));
        xfer(a[15:0], r);
        check("not ready", r, 32'(RSP_NOTRDY));
        fetch(sz, a);
    endtask : mem_rd
    task automatic dump(input logic [1:0] sz, input logic [31:0] a);
        logic [31:0] r;
        xfer({OP_DUMP, sz, 6'h00}, r);
        fetch(sz, a);
    endtask : dump
    task automatic mem_write(input logic [1:0] sz, input logic [31:0] a, d, input logic [15:0] nxt);
        logic [31:0] r, m;
        m = (32'h1 << (8 << sz)) - 32'h1;
        attr_bits <= 5'($random(seed));
        xfer({OP_WRITE, sz, 6'h00}, r);
        xfer(a[31:16], r);
        xfer(a[15:0], r);
        if (sz == SZ_LONG)
            xfer(d[31:16], r);
        xfer(d[15:0], r);
        poll(nxt, r);
        check("write status", r, err_en ? 32'(RSP_BERR) : 32'(RSP_DONE));
        check("write data", acc_wd & m, d & m);
        check("write address", acc_addr, a & ~((32'h1 << sz) - 32'h1));
        check("write attributes", {26'h0, acc_wr, acc_at}, {26'h0, 1'b1, attr_bits});
        check("write size", {30'h0, acc_sz}, {30'h0, sz});
    endtask : mem_write
    task automatic reg_w(input logic [3:0] sel, input logic [31:0] v, output logic [31:0] r);
        xfer({OP_WRREG, OP_REGGRP, sel}, r);
        xfer(v[31:16], r);
        xfer(v[15:0], r);
        poll(16'h0, r);
    endtask : reg_w
    initial
    begin : main
        logic [31:0] r, a, v;
        logic [3:0] sel;
        seed = 32'h0B2E;
        {rst, avs_read, avs_write, avs_address, avs_writedata, core_halted} = {3'h4, 36'h0, 1'b1};
        {attr_bits, mem_ack, mem_err, mem_rdata, err_en, clk_p, cap, dly} = 66'h0;
        {cyc, fail_count, n_checks} = {32'h0, 32'h0, 32'h0};
        for (s = 0; s < 16; s++)
            regs[s] = $random(seed);
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        av(4'hC, 1'b0, 32'h0, r);
        check("unmapped", r, 32'h0);
        av(HR_STAT, 1'b0, 32'h0, r);
        check("idle status", r, 32'h0);
        $display("test host registers done");
        sel = 4'($random(seed));
        v = $random(seed);
        reg_w(sel, v, r);
        check("reg write status", r, 32'(RSP_DONE));
        check("reg contents", regs[sel], v);
        xfer({OP_READ_DATA_REG_CMD, OP_REGGRP, sel}, r);
        poll(16'h0, r);
        check("reg upper", r, {16'h0, v[31:16]});
        xfer(16'h0, r);
        check("reg lower", r, {16'h0, v[15:0]});
        core_halted <= 1'b0;
        reg_w(sel, ~v, r);
        check("running write", r, 32'(RSP_BERR));
        check("reg kept", regs[sel], v);
        xfer({OP_READ_DATA_REG_CMD, OP_REGGRP, sel}, r);
        xfer(16'h0, r);
        check("running read", r, 32'(RSP_BERR));
        core_halted <= 1'b1;
        $display("test core registers done");
        for (s = 0; s < 3; s++)
            mem_rd(2'(s), $random(seed));
        err_en <= 1'b1;
        mem_rd(SZ_WORD, $random(seed));
        mem_write(SZ_LONG, $random(seed), $random(seed), 16'h0);
        err_en <= 1'b0;
        for (s = 0; s < 3; s++)
            mem_write(2'(s), $random(seed), $random(seed), 16'h0);
        mem_write(SZ_WORD, $random(seed), $random(seed), {OP_DUMP, SZ_WORD, 6'h00});
        xfer(16'h0, r);
        check("dump after write", r, 32'(RSP_ILL));
        xfer({OP_READ, SZ_RSVD, 6'h00}, r);
        xfer(16'h0, r);
        check("reserved size", r, 32'(RSP_ILL));
        $display("test memory access done");
        a = $random(seed) & 32'hFFFFFFFC;
        mem_rd(SZ_LONG, a);
        dump(SZ_LONG, a + 32'h4);
        dump(SZ_WORD, a + 32'h8);
        xfer(16'h0, r);
        check("pointer after null", bp_high_addr, a + 32'hA);
        dump(SZ_BYTE, a + 32'hA);
        $display("test block dump done");
        print_verdict();
    end
endmodule : debug_serial_reg_mem_access_tb
`default_nettype wire

//--- verification/dsa_link_asserts.sv
// wire-level checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module dsa_link_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic dsclk,
    input wire logic dsi,
    input wire logic dso
);
    logic clk_q;
    logic rise;
    logic [3:0] low_q;
    logic [4:0] rise_q;
    assign rise = dsclk && !clk_q;
    // a low run longer than a half bit marks the frame boundary
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_q <= 1'b0;
            low_q <= 4'h0;
            rise_q <= 5'h0;
        end
        else
        begin
            clk_q <= dsclk;
            low_q <= dsclk ? 4'h0 : (low_q == 4'hF ? low_q : low_q + 4'h1);
            rise_q <= (low_q == 4'h5) ? 5'h0 : rise_q + {4'h0, rise};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence high_half;
        dsclk [*4] ##1 !dsclk;
    endsequence
    sequence low_half;
        !dsclk [*4] ##1 dsclk;
    endsequence
    clk_high_a: assert property (rise |-> high_half) else $error("link clock high time wrong");
    clk_low_a: assert property ($fell(dsclk) && rise_q < 5'h11 |-> low_half) else $error("link clock low time wrong");
    frame_gap_a: assert property ($fell(dsclk) && rise_q == 5'h11 |-> !dsclk [*8]) else $error("gap too short");
    frame_len_a: assert property (low_q == 4'h5 && rise_q != 5'h0 |-> rise_q == 5'h11) else $error("frame length");
    rise_max_a: assert property (rise |-> rise_q < 5'h11) else $error("too many bits in frame");
    lead_zero_a: assert property (rise && rise_q == 5'h0 |-> !dsi) else $error("leading bit not zero");
    data_hold_a: assert property (dsclk && clk_q |-> $stable(dsi)) else $error("data moved while clock high");
    idle_reset_a: assert property ($fell(rst) |-> !dsclk && !dsi && !dso) else $error("link not idle");
endmodule : dsa_link_asserts
`default_nettype wire
